// File: sim/flash_cmd_properties.sv
// port assertions of the flash command decoder
// assumes lock pins and strap settle long before a final write
module flash_cmd_checker
    import flash_cmd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic reset_pin_n_in,
    input wire logic init_n_in,
    input wire logic oe_n_in,
    input wire logic top_block_lock_n_in,
    input wire logic write_protect_n_in,
    input wire logic [flash_cmd_pkg::GPI_W-1:0] general_inputs_in,
    input wire logic [flash_cmd_pkg::GPI_W-1:0] input_status_register_out,
    input wire logic dq_oe_out,
    input wire flash_cmd_pkg::array_req_t array_req_out,
    input wire logic refused_out,
    input wire logic id_mode_out,
    input wire logic pp_mode_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    wire logic req_v = array_req_out.valid;
    wire logic chip = array_req_out.op == op_chip_erase;
    wire logic top = array_req_out.addr[BLOCK_MSB:BLOCK_LSB] == TOP_BLOCK;
    sequence s_pin_rst; (!reset_pin_n_in)[*7]; endsequence
    sequence s_init_rst; (!init_n_in)[*7]; endsequence
    property p_req_pulse; req_v |=> !req_v; endproperty
    a_req_pulse: assert property (p_req_pulse)
        else $error("request longer than one cycle");
    property p_ref_pulse; refused_out |=> !refused_out; endproperty
    a_ref_pulse: assert property (p_ref_pulse)
        else $error("refusal longer than one cycle");
    property p_ref_excl; refused_out |-> !req_v; endproperty
    a_ref_excl: assert property (p_ref_excl)
        else $error("refused write still requested");
    property p_top; req_v && top && !chip |-> top_block_lock_n_in && $past(top_block_lock_n_in, 8);
    endproperty
    a_top: assert property (p_top)
        else $error("top block written while locked");
    property p_wp; req_v && !top && !chip |-> write_protect_n_in && $past(write_protect_n_in, 8);
    endproperty
    a_wp: assert property (p_wp)
        else $error("lower block written while protected");
    property p_chip; req_v && chip |-> pp_mode_out && top_block_lock_n_in && write_protect_n_in;
    endproperty
    a_chip: assert property (p_chip)
        else $error("chip erase outside parallel mode");
    property p_pin_rst; s_pin_rst |-> !dq_oe_out && !id_mode_out && !req_v; endproperty
    a_pin_rst: assert property (p_pin_rst)
        else $error("activity under reset pin");
    property p_init_rst; s_init_rst |-> !dq_oe_out && !id_mode_out && !req_v; endproperty
    a_init_rst: assert property (p_init_rst)
        else $error("activity under init pin");
    property p_oe_float; (oe_n_in)[*7] |-> !dq_oe_out; endproperty
    a_oe_float: assert property (p_oe_float)
        else $error("data driven without output enable");
    property p_gpi; (general_inputs_in == $past(general_inputs_in))[*7]
        |-> input_status_register_out == general_inputs_in; endproperty
    a_gpi: assert property (p_gpi)
        else $error("input status differs from pins");
endmodule : flash_cmd_checker

bind flash_command_decoder flash_cmd_checker chk (.clk_sys_in, .reset_n_in, .reset_pin_n_in,
    .init_n_in, .oe_n_in, .top_block_lock_n_in, .write_protect_n_in, .general_inputs_in,
    .input_status_register_out, .dq_oe_out, .array_req_out, .refused_out, .id_mode_out,
    .pp_mode_out);

// File: sim/flash_host_model.sv
// host model: parallel writes and reads, serial-path write pulses
// assumes the device samples every pin except the host bus write through a synchroniser
module flash_host_model
    import flash_cmd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic [7:0] dq_dev_in,
    input wire logic dq_oe_dev_in,
    output logic [flash_cmd_pkg::PIN_W-1:0] addr_pins_out,
    output logic row_col_sel_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic [7:0] dq_out,
    output logic hostbus_wr_valid_out,
    output flash_cmd_pkg::wr_cycle_t hostbus_wr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {addr_pins_out, row_col_sel_out, dq_out, hostbus_wr_valid_out, hostbus_wr_out} = '0;
        {oe_n_out, we_n_out} = 2'b11;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : wait_n
    task automatic put_addr(input logic [ADDR_W-1:0] a);
        row_col_sel_out = 1'b0;
        addr_pins_out = a[21:11];
        wait_n(4);
        row_col_sel_out = 1'b1;
        addr_pins_out = a[10:0];
        wait_n(4);
    endtask : put_addr
    // each write held 4 clocks, sequence cycles consecutive
    task automatic pwr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        put_addr(a);
        dq_out = d;
        we_n_out = 1'b0;
        wait_n(4);
        we_n_out = 1'b1;
        wait_n(1);
        dq_out = ~d;
        wait_n(3);
    endtask : pwr
    task automatic prd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output logic e);
        put_addr(a);
        oe_n_out = 1'b0;
        wait_n(6);
        d = dq_dev_in;
        e = dq_oe_dev_in;
        oe_n_out = 1'b1;
        wait_n(4);
    endtask : prd
    task automatic hwr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        hostbus_wr_out = '{addr: a, data: d};
        hostbus_wr_valid_out = 1'b1;
        wait_n(1);
        hostbus_wr_valid_out = 1'b0;
        hostbus_wr_out = ~hostbus_wr_out;
        wait_n(3);
    endtask : hwr
endmodule : flash_host_model

// File: sim/tb_flash_command_decoder.sv
// self-checking bench of the flash command decoder
// assumes the host model drives the parallel and serial write paths
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_flash_command_decoder import flash_cmd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, reset_n_in, reset_pin_n_in, init_n_in, parallel_programming_mode_in;
    logic row_col_sel_in, oe_n_in, we_n_in, dq_oe_out, refused_out, id_mode_out, pp_mode_out;
    logic top_block_lock_n_in, write_protect_n_in, hostbus_wr_valid_in, rd_oe;
    logic [PIN_W-1:0] addr_pins_in;
    logic [7:0] dq_in, dq_out, rd;
    logic [GPI_W-1:0] general_inputs_in, input_status_register_out;
    logic [ADDR_W-1:0] array_addr_out;
    wr_cycle_t hostbus_wr_in;
    array_req_t array_req_out, last_req;
    int error_cnt, checks, req_cnt, ref_cnt;
    wire logic [7:0] array_rd_data_in = array_addr_out[7:0] ^ 8'h5a;
    flash_command_decoder uut (.clk_sys_in, .reset_n_in, .reset_pin_n_in, .init_n_in,
        .parallel_programming_mode_in, .addr_pins_in, .row_col_sel_in, .oe_n_in, .we_n_in,
        .dq_in, .dq_out, .dq_oe_out, .top_block_lock_n_in, .write_protect_n_in,
        .general_inputs_in, .input_status_register_out, .hostbus_wr_valid_in, .hostbus_wr_in,
        .array_rd_data_in, .array_addr_out, .array_req_out, .refused_out, .id_mode_out,
        .pp_mode_out);
    flash_host_model host (.clk_sys_in, .dq_dev_in(dq_out), .dq_oe_dev_in(dq_oe_out),
        .addr_pins_out(addr_pins_in), .row_col_sel_out(row_col_sel_in), .oe_n_out(oe_n_in),
        .we_n_out(we_n_in), .dq_out(dq_in), .hostbus_wr_valid_out(hostbus_wr_valid_in),
        .hostbus_wr_out(hostbus_wr_in));
    always @(negedge clk_sys_in) begin
        if (array_req_out.valid === 1'b1) begin
            req_cnt++;
            last_req = array_req_out;
        end
        if (refused_out === 1'b1) ref_cnt++;
    end
    task automatic unl(input logic [7:0] c);
        host.pwr({7'h7f, CMD_ADDR_A}, CMD_UNLOCK_A);
        host.pwr({7'h2a, CMD_ADDR_B}, CMD_UNLOCK_B);
        host.pwr({7'h00, CMD_ADDR_A}, c);
    endtask : unl
    task automatic settle(input int r, input int f);
        host.wait_n(8);
        `CHK(req_cnt, r)
        `CHK(ref_cnt, f)
        req_cnt = 0;
        ref_cnt = 0;
    endtask : settle
    task automatic t_program;
        unl(CMD_PROGRAM);
        host.pwr(22'h012345, 8'h5a);
        settle(1, 0);
        `CHK(last_req.op, op_program)
        `CHK(last_req.addr, 22'h012345)
        `CHK(last_req.data, 8'h5a)
        unl(8'h77);
        host.pwr(22'h012345, 8'h11);
        settle(0, 0);
        $display("program and abort done");
    endtask : t_program
    task automatic t_erase;
        logic [7:0] code [3] = '{CMD_SECTOR_ERASE, CMD_BLOCK_ERASE, CMD_CHIP_ERASE};
        logic [ADDR_W-1:0] ea [3] = '{22'h023456, 22'h045678, 22'h005555};
        logic [ADDR_W-1:0] em [3] = '{SECTOR_MASK, BLOCK_MASK, ZERO_ADDR};
        array_op_t eop [3] = '{op_sector_erase, op_block_erase, op_chip_erase};
        for (int i = 0; i < 3; i++) begin
            unl(CMD_ERASE_SETUP);
            host.pwr({7'h7f, CMD_ADDR_A}, CMD_UNLOCK_A);
            host.pwr({7'h00, CMD_ADDR_B}, CMD_UNLOCK_B);
            host.pwr(ea[i], code[i]);
            settle(1, 0);
            `CHK(last_req.op, eop[i])
            `CHK(last_req.addr, ea[i] & em[i])
        end
        $display("erase done");
    endtask : t_erase
    task automatic t_protect;
        logic [ADDR_W-1:0] pa [4] = '{22'h034567, 22'h0f0010, 22'h0f0010, 22'h034567};
        for (int i = 0; i < 4; i++) begin
            write_protect_n_in = i > 1;
            top_block_lock_n_in = i < 2;
            unl(CMD_PROGRAM);
            host.pwr(pa[i], 8'h3e);
            settle(i % 2, 1 - i % 2);
        end
        {write_protect_n_in, top_block_lock_n_in} = 2'b11;
        $display("protect done");
    endtask : t_protect
    task automatic t_id;
        unl(CMD_ID_ENTRY);
        host.prd(22'h000000, rd, rd_oe);
        `CHK({rd, rd_oe}, {MAKER_CODE, 1'b1})
        host.prd(22'h000001, rd, rd_oe);
        `CHK(rd, PART_CODE)
        host.pwr(22'h001234, CMD_ID_EXIT);
        host.wait_n(6);
        `CHK(id_mode_out, 1'b0)
        unl(CMD_ID_ENTRY);
        host.wait_n(6);
        `CHK(id_mode_out, 1'b1)
        unl(CMD_ID_EXIT);
        host.prd(22'h000123, rd, rd_oe);
        `CHK({id_mode_out, rd}, {1'b0, 8'h23 ^ 8'h5a})
        $display("identification done");
    endtask : t_id
    task automatic t_reset;
        for (int i = 0; i < 3; i++) begin
            unl(CMD_ID_ENTRY);
            init_n_in = i != 1;
            reset_pin_n_in = i == 1;
            parallel_programming_mode_in = i != 2;
            host.wait_n(10);
            `CHK({id_mode_out, dq_oe_out}, 2'b00)
            {init_n_in, reset_pin_n_in} = 2'b11;
            host.wait_n(8);
        end
        reset_n_in = 1'b0;
        host.wait_n(2);
        `CHK({array_req_out.valid, dq_oe_out, pp_mode_out}, 3'b000)
        reset_n_in = 1'b1;
        host.wait_n(8);
        `CHK(pp_mode_out, 1'b0)
        $display("reset done");
    endtask : t_reset
    task automatic t_host;
        wr_cycle_t hs [5] = '{'{22'h005555, 8'haa}, '{22'h002aaa, 8'h55},
            '{22'h005555, 8'h80}, '{22'h005555, 8'haa}, '{22'h002aaa, 8'h55}};
        for (int j = 0; j < 2; j++) begin
            for (int k = 0; k < 5; k++) host.hwr(hs[k].addr, hs[k].data);
            host.hwr(j ? 22'h023000 : 22'h005555, j ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE);
            settle(j, 0);
        end
        $display("host path done");
    endtask : t_host
    task automatic t_gpi;
        for (int i = 0; i < 2; i++) begin
            general_inputs_in = 5'h15 ^ {GPI_W{i[0]}}; // held steady until read
            host.wait_n(6);
            `CHK(input_status_register_out, general_inputs_in)
        end
        $display("input status done");
    endtask : t_gpi
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #80000;
        error_cnt++;
        summarize();
    end
    initial begin
        {reset_n_in, general_inputs_in} = '0;
        {reset_pin_n_in, init_n_in, parallel_programming_mode_in} = 3'b111;
        {top_block_lock_n_in, write_protect_n_in} = 2'b11;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in) reset_n_in = 1'b1;
        host.wait_n(6);
        t_gpi();
        t_program();
        t_erase();
        t_protect();
        t_id();
        t_reset();
        t_host();
        summarize();
    end
endmodule : tb_flash_command_decoder

// File: verilog/flash_cmd_pkg.sv
// constants, types and command codes of the flash command decoder
// assumes a single 250 MHz system clock and the array engine outside
package flash_cmd_pkg;
    localparam int ADDR_W = 22;
    localparam int PIN_W = 11;
    localparam int CMD_W = 15;
    localparam int GPI_W = 5;
    localparam logic [CMD_W-1:0] CMD_ADDR_A = 15'h5555;
    localparam logic [CMD_W-1:0] CMD_ADDR_B = 15'h2aaa;
    localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
    localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
    // identification codes: arbitrary values
    localparam logic [7:0] MAKER_CODE = 8'h3c;
    localparam logic [7:0] PART_CODE = 8'hc3;
    // array geometry: 4 KByte sectors, 64 KByte blocks, top block is boot block
    localparam logic [ADDR_W-1:0] SECTOR_MASK = 22'h3ff000;
    localparam logic [ADDR_W-1:0] BLOCK_MASK = 22'h3f0000;
    localparam int BLOCK_LSB = 16;
    localparam int BLOCK_MSB = 19;
    localparam logic [3:0] TOP_BLOCK = 4'hf;
    localparam int ID_SEL_MSB = 18;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 22'h000000;

    typedef enum logic [2:0] {
        st_read = 3'b000,
        st_unlock1 = 3'b001,
        st_unlock2 = 3'b010,
        st_program = 3'b011,
        st_erase1 = 3'b100,
        st_erase2 = 3'b101,
        st_erase3 = 3'b110
    } seq_state_t;

    typedef enum logic [2:0] {
        op_none = 3'b000,
        op_program = 3'b001,
        op_sector_erase = 3'b010,
        op_block_erase = 3'b011,
        op_chip_erase = 3'b100
    } array_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } wr_cycle_t;

    typedef struct packed {
        logic valid;
        array_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } array_req_t;
endpackage : flash_cmd_pkg

// File: verilog/flash_command_decoder.sv
// command front end of a byte-wide boot flash: pin sync, write decode,
// command sequences, identification reads and hardware write protection
// assumes one clock, an external array engine and an external serial front end
// How it works
// - general input levels shown on status register
// - top block lock low refuses top block
// - write protect low refuses all lower blocks
// - row/column select steers shared address pins
// - erase address is sector/block, ignored for chip
// - four writes program one byte
// - six writes, last 30h, erase sector
// - six writes, last 50h, erase block
// - six writes, 10h at 5555h, erase chip
// - three writes enter identification, a0 selects code
// - single f0h or three-write exit leave identification
// - command addresses decoded on bits 14..0
// - chip erase accepted in parallel mode only
// - init pin low acts as reset pin low

module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] level_ff;
    wire logic [W-1:0] agree = ~(s2_ff ^ s3_ff);
    wire logic [W-1:0] nxt_level = (s3_ff & agree) | (level_ff & ~agree);

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            level_ff <= RST_VAL;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level_out = level_ff;
endmodule : pin_sync3

module flash_command_decoder
    import flash_cmd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic reset_pin_n_in,
    input wire logic init_n_in,
    input wire logic parallel_programming_mode_in,
    input wire logic [flash_cmd_pkg::PIN_W-1:0] addr_pins_in,
    input wire logic row_col_sel_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe_out,
    input wire logic top_block_lock_n_in,
    input wire logic write_protect_n_in,
    input wire logic [flash_cmd_pkg::GPI_W-1:0] general_inputs_in,
    output logic [flash_cmd_pkg::GPI_W-1:0] input_status_register_out,
    input wire logic hostbus_wr_valid_in,
    input wire flash_cmd_pkg::wr_cycle_t hostbus_wr_in,
    input wire logic [7:0] array_rd_data_in,
    output logic [flash_cmd_pkg::ADDR_W-1:0] array_addr_out,
    output flash_cmd_pkg::array_req_t array_req_out,
    output logic refused_out,
    output logic id_mode_out,
    output logic pp_mode_out
);
    import flash_cmd_pkg::*;

    localparam int CTRL_W = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h1c;
    localparam int BUS_W = PIN_W + 8;

    // synchronised pin levels
    logic [CTRL_W-1:0] ctrl_s;
    logic [BUS_W-1:0] bus_s;
    logic [GPI_W-1:0] gpi_s;

    pin_sync3 #(.W(CTRL_W), .RST_VAL(CTRL_RST)) u_ctrl_sync (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in({reset_pin_n_in, init_n_in, oe_n_in, we_n_in, row_col_sel_in,
                 top_block_lock_n_in, write_protect_n_in, parallel_programming_mode_in}),
        .level_out(ctrl_s)
    );

    pin_sync3 #(.W(BUS_W), .RST_VAL('0)) u_bus_sync (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in({addr_pins_in, dq_in}),
        .level_out(bus_s)
    );

    pin_sync3 #(.W(GPI_W), .RST_VAL('0)) u_gpi_sync (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in(general_inputs_in),
        .level_out(gpi_s)
    );

    wire logic rst_pin_n_s = ctrl_s[7];
    wire logic init_n_s = ctrl_s[6];
    wire logic oe_n_s = ctrl_s[5];
    wire logic we_n_s = ctrl_s[4];
    wire logic row_col_s = ctrl_s[3];
    wire logic tbl_n_s = ctrl_s[2];
    wire logic wp_n_s = ctrl_s[1];
    wire logic ic_s = ctrl_s[0];
    wire logic [PIN_W-1:0] addr_pins_s = bus_s[BUS_W-1:8];
    wire logic [7:0] dq_s = bus_s[7:0];

    // one internal reset from both reset pins
    wire logic dev_run = rst_pin_n_s & init_n_s;

    logic [GPI_W-1:0] input_status_register_ff;
    logic pp_mode_ff;
    logic strap_taken_ff;
    logic [PIN_W-1:0] row_ff;
    logic [PIN_W-1:0] col_ff;
    logic we_n_prev_ff;
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic id_mode_ff;
    logic nxt_id_mode;
    array_req_t req_ff;
    array_req_t nxt_req;
    logic refused_ff;
    logic nxt_refused;
    logic [7:0] dq_ff;
    logic dq_oe_ff;

    // address assembly and write strobe
    wire logic [ADDR_W-1:0] pp_addr = {row_ff, col_ff};
    wire logic pp_wr = dev_run & pp_mode_ff & oe_n_s & we_n_prev_ff & ~we_n_s;
    wire logic host_wr = dev_run & ~pp_mode_ff & hostbus_wr_valid_in;
    wire logic wr_evt = pp_wr | host_wr;
    wire logic [ADDR_W-1:0] wr_addr = pp_mode_ff ? {row_ff, col_ff} : hostbus_wr_in.addr;
    wire logic [7:0] wr_data = pp_mode_ff ? dq_s : hostbus_wr_in.data;
    wire logic [CMD_W-1:0] cmd_addr = wr_addr[CMD_W-1:0];
    wire logic at_a = cmd_addr == CMD_ADDR_A;
    wire logic at_b = cmd_addr == CMD_ADDR_B;
    wire logic wr_unlock_a = at_a & (wr_data == CMD_UNLOCK_A);
    wire logic wr_unlock_b = at_b & (wr_data == CMD_UNLOCK_B);
    wire logic wr_exit = wr_data == CMD_ID_EXIT;

    // hardware write protection
    wire logic [3:0] wr_block = wr_addr[BLOCK_MSB:BLOCK_LSB];
    wire logic in_top = wr_block == TOP_BLOCK;
    wire logic top_locked = ~tbl_n_s & in_top;
    wire logic low_locked = ~wp_n_s & ~in_top;
    wire logic addr_locked = top_locked | low_locked;
    wire logic any_lock = ~tbl_n_s | ~wp_n_s;
    wire logic chip_ok = pp_mode_ff & at_a;

    // identification read select
    wire logic id_sel = pp_addr[ID_SEL_MSB:1] == '0;
    wire logic [7:0] id_code = pp_addr[0] ? PART_CODE : MAKER_CODE;
    wire logic [7:0] rd_data = (id_mode_ff & id_sel) ? id_code : array_rd_data_in;
    wire logic rd_drive = dev_run & pp_mode_ff & ~oe_n_s & we_n_s;

    // command sequence decode
    always_comb begin
        nxt_state = state_ff;
        nxt_id_mode = id_mode_ff;
        nxt_req = '{valid: 1'b0, op: op_none, addr: ZERO_ADDR, data: 8'h00};
        nxt_refused = 1'b0;
        if (wr_evt) begin
            nxt_state = st_read;
            if (wr_exit && state_ff != st_unlock2 && state_ff != st_program) begin
                nxt_id_mode = 1'b0;
            end else begin
                unique case (state_ff)
                    st_read: begin
                        if (wr_unlock_a) begin
                            nxt_state = st_unlock1;
                        end
                    end
                    st_unlock1: begin
                        if (wr_unlock_b) begin
                            nxt_state = st_unlock2;
                        end
                    end
                    st_unlock2: begin
                        if (at_a && wr_data == CMD_PROGRAM) begin
                            nxt_state = st_program;
                        end else if (at_a && wr_data == CMD_ERASE_SETUP) begin
                            nxt_state = st_erase1;
                        end else if (at_a && wr_data == CMD_ID_ENTRY) begin
                            nxt_id_mode = 1'b1;
                        end else if (at_a && wr_exit) begin
                            nxt_id_mode = 1'b0;
                        end
                    end
                    st_program: begin
                        // data byte goes to the full target address
                        nxt_req.op = op_program;
                        nxt_req.addr = wr_addr;
                        nxt_req.data = wr_data;
                        nxt_req.valid = ~addr_locked;
                        nxt_refused = addr_locked;
                    end
                    st_erase1: begin
                        if (wr_unlock_a) begin
                            nxt_state = st_erase2;
                        end
                    end
                    st_erase2: begin
                        if (wr_unlock_b) begin
                            nxt_state = st_erase3;
                        end
                    end
                    st_erase3: begin
                        if (wr_data == CMD_SECTOR_ERASE) begin
                            nxt_req.op = op_sector_erase;
                            nxt_req.addr = wr_addr & SECTOR_MASK;
                            nxt_req.valid = ~addr_locked;
                            nxt_refused = addr_locked;
                        end else if (wr_data == CMD_BLOCK_ERASE) begin
                            nxt_req.op = op_block_erase;
                            nxt_req.addr = wr_addr & BLOCK_MASK;
                            nxt_req.valid = ~addr_locked;
                            nxt_refused = addr_locked;
                        end else if (wr_data == CMD_CHIP_ERASE && chip_ok) begin
                            nxt_req.op = op_chip_erase;
                            nxt_req.addr = ZERO_ADDR;
                            nxt_req.valid = ~any_lock;
                            nxt_refused = any_lock;
                        end
                    end
                    default: begin
                        nxt_state = st_read;
                    end
                endcase
            end
        end
    end

    // strap, address latches and pin history
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_taken_ff <= 1'b0;
            pp_mode_ff <= 1'b0;
            row_ff <= '0;
            col_ff <= '0;
            we_n_prev_ff <= 1'b1;
            input_status_register_ff <= '0;
        end else begin
            strap_taken_ff <= dev_run;
            if (dev_run && !strap_taken_ff) begin
                pp_mode_ff <= ic_s;
            end
            if (dev_run && !row_col_s) begin
                row_ff <= addr_pins_s;
            end
            if (dev_run && row_col_s) begin
                col_ff <= addr_pins_s;
            end
            we_n_prev_ff <= we_n_s;
            input_status_register_ff <= gpi_s;
        end
    end

    // sequence state, requests and data pins
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= st_read;
            id_mode_ff <= 1'b0;
            req_ff <= '{valid: 1'b0, op: op_none, addr: ZERO_ADDR, data: 8'h00};
            refused_ff <= 1'b0;
            dq_ff <= 8'h00;
            dq_oe_ff <= 1'b0;
        end else if (!dev_run) begin
            state_ff <= st_read;
            id_mode_ff <= 1'b0;
            req_ff <= '{valid: 1'b0, op: op_none, addr: ZERO_ADDR, data: 8'h00};
            refused_ff <= 1'b0;
            dq_oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            id_mode_ff <= nxt_id_mode;
            req_ff <= nxt_req;
            refused_ff <= nxt_refused;
            dq_ff <= rd_data;
            dq_oe_ff <= rd_drive;
        end
    end

    assign dq_out = dq_ff;
    assign dq_oe_out = dq_oe_ff;
    assign input_status_register_out = input_status_register_ff;
    assign array_addr_out = pp_addr;
    assign array_req_out = req_ff;
    assign refused_out = refused_ff;
    assign id_mode_out = id_mode_ff;
    assign pp_mode_out = pp_mode_ff;
endmodule : flash_command_decoder
